/* design/external_memory_interface.sv */
// External data memory interface: routes core moves to on-chip RAM or the off-chip bus.
// Assumes core request inputs synchronous to clk; pin output enables are active low.
// Function
// R1: Bit 4 of config selects bus arrangement
// R2: Zero means multiplexed, one means separate pins
// R3: Multiplexed mode shares data and low address
// R4: Device generates the address latch strobe
// R5: Latch strobe high while low address shown
// R6: External latch freezes low address on fall
// R7: Second multiplexed phase carries data with strobe
// R8: Non-multiplexed mode uses separate address, data pins
// R9: Mode 00 accesses only on-chip memory
// R10: Internal-only addresses wrap modulo on-chip size
// R11: Eight-bit move address is page plus pointer
// R12: Sixteen-bit move address is data pointer
// R13: Mode 01 splits on-chip and off-chip by size
// R14: Mode 01 eight-bit leaves upper address undriven
// R15: Sixteen-bit off-chip drives all address bits
// R16: Mode 10 drives upper byte from page
// R17: Mode 11 sends every move off-chip
// R18: Mode 11 eight-bit ignores page, upper undriven
// R19: Setup, hold, strobe, latch widths programmable
// R20: Off-chip move adds four fixed cycles
// R21: Multiplexed latch phases add two cycles minimum
// R22: Setup and hold reset to maximum
// R23: Latch high and low width is field plus one
// R24: Address setup equals field value in cycles
// R25: Strobe width equals field plus one
// R26: On-chip accesses assert no external strobes
`default_nettype none
module external_memory_interface #(
	parameter int EXTERNAL_RAM_SPACE_AW = xmem_pkg::EXTERNAL_RAM_SPACE_AW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	input wire logic timing_wr,
	input wire logic [7:0] timing_wdata,
	input wire logic page_wr,
	input wire logic [7:0] page_wdata,
	input wire logic req,
	input wire logic req_wide,
	input wire logic req_write,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] low_pointer,
	input wire logic [7:0] req_wdata,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output logic [7:0] interface_config_reg,
	output logic [7:0] interface_timing_reg,
	output logic [7:0] upper_page_reg,
	output logic [7:0] addr_hi_out,
	output logic addr_hi_oe_n,
	output logic [7:0] addr_lo_out,
	output logic addr_lo_oe_n,
	output logic [7:0] data_out,
	output logic data_oe_n,
	input wire logic [7:0] data_in,
	output logic ale,
	output logic rd_n,
	output logic wr_n
);
	typedef enum logic [3:0] {IDLE, INT, START, ALE_H, ALE_L, SETUP, STROBE, HOLD, TAIL} phase_t;
	typedef struct packed {
		phase_t ph;
		logic [7:0] cfg;
		logic [7:0] tc;
		logic [7:0] page;
		logic [3:0] cnt;
		logic is_write;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic busy;
		logic done;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [7:0] hi_out;
		logic hi_oe_n;
		logic [7:0] lo_out;
		logic lo_oe_n;
		logic [7:0] d_out;
		logic d_oe_n;
	} state_t;

	state_t r_reg;
	state_t r_next;
	logic mux;
	logic [1:0] mode;
	logic [1:0] eale;
	logic [1:0] eas;
	logic [3:0] ewr;
	logic [1:0] eah;
	logic [15:0] eff;
	logic onchip;
	logic drive_hi;
	logic accept;
	logic mem_en;
	logic [7:0] mem_rdata;

	assign mux = ~r_reg.cfg[xmem_pkg::MUX_BIT]; // R1 R2
	assign mode = r_reg.cfg[xmem_pkg::MODE_LSB +: 2];
	assign eale = r_reg.cfg[xmem_pkg::ALE_LSB +: 2];
	assign eas = r_reg.tc[xmem_pkg::EAS_LSB +: 2];
	assign ewr = r_reg.tc[xmem_pkg::EWR_LSB +: 4];
	assign eah = r_reg.tc[xmem_pkg::EAH_LSB +: 2];
	assign eff = req_wide ? data_pointer : {r_reg.page, low_pointer}; // R11 R12
	// R9 R13 R17
	assign onchip = (mode == xmem_pkg::MODE_INT_ONLY) ||
		((mode != xmem_pkg::MODE_EXT_ONLY) && (eff[15:EXTERNAL_RAM_SPACE_AW] == '0));
	assign drive_hi = req_wide || (mode == xmem_pkg::MODE_SPLIT_BANK); // R14 R15 R16 R18
	assign accept = (r_reg.ph == IDLE) && req;
	assign mem_en = accept && onchip;

	onchip_external_ram_space #(.AW(EXTERNAL_RAM_SPACE_AW)) u_external_ram_space (
		.clk(clk),
		.en(mem_en),
		.we(req_write),
		.addr(eff[EXTERNAL_RAM_SPACE_AW-1:0]), // R10
		.wdata(req_wdata),
		.rdata(mem_rdata)
	);

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (cfg_wr) begin
			r_next.cfg = cfg_wdata;
		end
		if (timing_wr) begin
			r_next.tc = timing_wdata; // R19
		end
		if (page_wr) begin
			r_next.page = page_wdata;
		end
		case (r_reg.ph)
			IDLE: begin
				if (req) begin
					r_next.busy = 1'b1;
					r_next.is_write = req_write;
					r_next.wdata = req_wdata;
					if (onchip) begin
						r_next.ph = INT; // R26
					end else begin
						r_next.ph = START;
						r_next.hi_out = eff[15:8];
						r_next.hi_oe_n = ~drive_hi; // R14 R16 R18
						if (mux) begin
							r_next.d_out = eff[7:0]; // R3
							r_next.d_oe_n = 1'b0;
						end else begin
							r_next.lo_out = eff[7:0]; // R8
							r_next.lo_oe_n = 1'b0;
							r_next.d_out = req_wdata;
							r_next.d_oe_n = ~req_write;
						end
					end
				end
			end
			INT: begin
				if (!r_reg.is_write) begin
					r_next.rdata = mem_rdata;
				end
				r_next.done = 1'b1;
				r_next.busy = 1'b0;
				r_next.ph = IDLE;
			end
			START: begin
				if (mux) begin
					r_next.ph = ALE_H;
					r_next.ale = 1'b1; // R4 R5
					r_next.cnt = {2'h0, eale}; // R23
				end else if (eas == 2'h0) begin
					r_next.ph = STROBE;
					r_next.rd_n = r_reg.is_write;
					r_next.wr_n = ~r_reg.is_write;
					r_next.cnt = ewr; // R25
				end else begin
					r_next.ph = SETUP;
					r_next.cnt = {2'h0, eas - 2'h1}; // R24
				end
			end
			ALE_H: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.ph = ALE_L;
					r_next.ale = 1'b0; // R6
					r_next.cnt = {2'h0, eale}; // R21 R23
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			ALE_L: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.d_out = r_reg.wdata; // R7
					r_next.d_oe_n = ~r_reg.is_write;
					if (eas == 2'h0) begin
						r_next.ph = STROBE;
						r_next.rd_n = r_reg.is_write;
						r_next.wr_n = ~r_reg.is_write;
						r_next.cnt = ewr;
					end else begin
						r_next.ph = SETUP;
						r_next.cnt = {2'h0, eas - 2'h1};
					end
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			SETUP: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.ph = STROBE;
					r_next.rd_n = r_reg.is_write;
					r_next.wr_n = ~r_reg.is_write;
					r_next.cnt = ewr;
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			STROBE: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.rd_n = 1'b1;
					r_next.wr_n = 1'b1;
					if (!r_reg.is_write) begin
						r_next.rdata = data_in;
					end
					if (eah == 2'h0) begin
						r_next.ph = TAIL;
						r_next.cnt = xmem_pkg::TAIL_LAST;
					end else begin
						r_next.ph = HOLD;
						r_next.cnt = {2'h0, eah - 2'h1};
					end
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			HOLD: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.ph = TAIL;
					r_next.cnt = xmem_pkg::TAIL_LAST;
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			TAIL: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.ph = IDLE; // R20
					r_next.done = 1'b1;
					r_next.busy = 1'b0;
					r_next.hi_oe_n = 1'b1;
					r_next.lo_oe_n = 1'b1;
					r_next.d_oe_n = 1'b1;
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			default: begin
				r_next.ph = IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_reg <= '{ph: IDLE, cfg: xmem_pkg::CFG_RESET, tc: xmem_pkg::TC_RESET, // R22
				page: 8'h00, cnt: 4'h0, is_write: 1'b0, wdata: 8'h00, rdata: 8'h00,
				busy: 1'b0, done: 1'b0, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
				hi_out: 8'h00, hi_oe_n: 1'b1, lo_out: 8'h00, lo_oe_n: 1'b1,
				d_out: 8'h00, d_oe_n: 1'b1};
		end else begin
			r_reg <= r_next;
		end
	end

	assign busy = r_reg.busy;
	assign done = r_reg.done;
	assign rdata = r_reg.rdata;
	assign interface_config_reg = r_reg.cfg;
	assign interface_timing_reg = r_reg.tc;
	assign upper_page_reg = r_reg.page;
	assign addr_hi_out = r_reg.hi_out;
	assign addr_hi_oe_n = r_reg.hi_oe_n;
	assign addr_lo_out = r_reg.lo_out;
	assign addr_lo_oe_n = r_reg.lo_oe_n;
	assign data_out = r_reg.d_out;
	assign data_oe_n = r_reg.d_oe_n;
	assign ale = r_reg.ale;
	assign rd_n = r_reg.rd_n;
	assign wr_n = r_reg.wr_n;

	// Length checker for off-chip moves
	logic [5:0] len_reg;
	logic [5:0] exp_reg;
	logic ext_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			len_reg <= 6'h00;
			exp_reg <= 6'h00;
			ext_reg <= 1'b0;
		end else if (accept) begin
			len_reg <= 6'h01;
			ext_reg <= !onchip;
			exp_reg <= 6'(xmem_pkg::OVERHEAD_CYC) + {4'h0, eas} + {2'h0, ewr} + 6'h01 + {4'h0, eah}
				+ (mux ? ({4'h0, eale} + 6'h01) << 1 : 6'h00);
		end else if (r_reg.busy) begin
			len_reg <= len_reg + 6'h01;
		end
	end

	a_ext_length: assert property (@(posedge clk) disable iff (!rst_n) // R20
		(done && ext_reg) |-> (len_reg == exp_reg))
		else $error("off-chip move length wrong");
	a_mux_min: assert property (@(posedge clk) disable iff (!rst_n) // R21
		(done && ext_reg && mux) |-> (len_reg >= 6'h07))
		else $error("multiplexed move shorter than seven cycles");
	a_int_only: assert property (@(posedge clk) disable iff (!rst_n) // R9
		(accept && mode == xmem_pkg::MODE_INT_ONLY) |=> (r_reg.ph == INT) ##1 (done && rd_n && wr_n))
		else $error("internal-only move left the chip");
	a_onchip_quiet: assert property (@(posedge clk) disable iff (!rst_n) // R26
		(r_reg.ph == INT) |-> (rd_n && wr_n && !ale && addr_hi_oe_n && data_oe_n))
		else $error("on-chip move drove bus strobes");
	a_ext_all: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(accept && mode == xmem_pkg::MODE_EXT_ONLY) |=> (r_reg.ph == START))
		else $error("external-only move stayed on chip");
	a_ale_addr: assert property (@(posedge clk) disable iff (!rst_n) // R5
		$rose(ale) |-> (!data_oe_n && data_out == $past(data_out) && rd_n && wr_n))
		else $error("latch strobe without low address");
	a_nomux_ale: assert property (@(posedge clk) disable iff (!rst_n) // R8
		(r_reg.ph == START && !mux) |=> (!ale && !addr_lo_oe_n))
		else $error("separate-pin mode misused latch or address pins");
	a_hi_undriven: assert property (@(posedge clk) disable iff (!rst_n) // R14
		(accept && !onchip && !req_wide && mode != xmem_pkg::MODE_SPLIT_BANK) |=> addr_hi_oe_n)
		else $error("upper address driven without bank select");
	a_hi_bank: assert property (@(posedge clk) disable iff (!rst_n) // R16
		(accept && !onchip && !req_wide && mode == xmem_pkg::MODE_SPLIT_BANK)
		|=> (!addr_hi_oe_n && addr_hi_out == $past(r_reg.page)))
		else $error("bank select upper byte wrong");
	a_wide_addr: assert property (@(posedge clk) disable iff (!rst_n) // R15
		(accept && !onchip && req_wide) |=> (!addr_hi_oe_n && addr_hi_out == $past(data_pointer[15:8])))
		else $error("wide move upper address wrong");
	a_reset_tc: assert property (@(posedge clk) // R22
		!rst_n |=> (interface_timing_reg == xmem_pkg::TC_RESET))
		else $error("timing not at maximum after reset");
endmodule
`default_nettype wire

/* design/xmem_pkg.sv */
// Package: constants shared by the external data memory interface.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
`default_nettype none
package xmem_pkg;
	// Interface configuration register fields
	localparam int MUX_BIT = 4;
	localparam int MODE_LSB = 2;
	localparam int ALE_LSB = 0;
	localparam logic [7:0] CFG_RESET = 8'h03;
	// Interface timing register fields
	localparam int EAS_LSB = 6;
	localparam int EWR_LSB = 2;
	localparam int EAH_LSB = 0;
	localparam logic [7:0] TC_RESET = 8'hFF;
	// Memory mode codes
	localparam logic [1:0] MODE_INT_ONLY = 2'h0;
	localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
	localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
	localparam logic [1:0] MODE_EXT_ONLY = 2'h3;
	// Fixed overhead of an off-chip move: one lead cycle, two tail cycles, then the done cycle
	localparam int OVERHEAD_CYC = 4;
	localparam int LEAD_CYC = 1;
	localparam logic [3:0] TAIL_LAST = 4'(OVERHEAD_CYC - LEAD_CYC - 2);
	// Default on-chip memory address width (4k)
	localparam int EXTERNAL_RAM_SPACE_AW = 12;
endpackage
`default_nettype wire

/* design/onchip_external_ram_space.sv */
// On-chip data RAM: one synchronous write port, registered read.
// Assumes address already reduced to the on-chip size.
`default_nettype none
module onchip_external_ram_space #(
	parameter int AW = 12
) (
	input wire logic clk,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule
`default_nettype wire

/* tb/ext_mem_model.sv */
// Off-chip asynchronous byte memory with a transparent low-address latch.
// Assumes the pin ports of the memory interface block and one clock.
`default_nettype none
module ext_mem_model #(
	parameter logic [7:0] PORT_HI = 8'hC3
) (
	input wire logic clk,
	input wire logic mux,
	input wire logic [7:0] addr_hi_out,
	input wire logic addr_hi_oe_n,
	input wire logic [7:0] addr_lo_out,
	input wire logic [7:0] data_out,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [7:0] lat_q;
	logic [7:0] last_q = 8'h00;
	logic [15:0] a;
	// Latch passes while high, freezes on fall
	always_latch if (ale) lat_q <= data_out;
	// Undriven upper pins keep the port latch value
	assign a = {addr_hi_oe_n ? PORT_HI : addr_hi_out, mux ? lat_q : addr_lo_out};
	// Released bus shows the inverse of its last value
	assign data_in = rd_n ? ~last_q : mem[a];
	always @(posedge clk) begin
		if (!wr_n) mem[a] <= data_out;
		if (!rd_n) last_q <= mem[a];
	end
endmodule
`default_nettype wire

/* tb/external_memory_interface_bench.sv */
// Self-checking bench for the external data memory interface.
// Assumes the design package and the off-chip memory model.
`default_nettype none
module external_memory_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, timing_wr = 1'b0, page_wr = 1'b0;
	logic req = 1'b0, req_wide = 1'b0, req_write = 1'b0;
	logic [7:0] cfg_wdata = 8'h00, timing_wdata = 8'h00, page_wdata = 8'h00;
	logic [7:0] low_pointer = 8'h00, req_wdata = 8'h00;
	logic [15:0] data_pointer = 16'h0000;
	logic busy, done, addr_hi_oe_n, addr_lo_oe_n, data_oe_n, ale, rd_n, wr_n, mux, hi_drv;
	logic [7:0] rdata, interface_config_reg, interface_timing_reg, upper_page_reg;
	logic [7:0] addr_hi_out, addr_lo_out, data_out, data_in, ale_ad, stb_hi, stb_lo, stb_d;
	int err_total = 0, n_checks = 0, n_cyc, n_ale, n_stb;
	assign mux = ~interface_config_reg[xmem_pkg::MUX_BIT];
	external_memory_interface dut (.clk, .rst_n, .cfg_wr, .cfg_wdata, .timing_wr, .timing_wdata,
		.page_wr, .page_wdata, .req, .req_wide, .req_write, .data_pointer, .low_pointer, .req_wdata,
		.busy, .done, .rdata, .interface_config_reg, .interface_timing_reg, .upper_page_reg,
		.addr_hi_out, .addr_hi_oe_n, .addr_lo_out, .addr_lo_oe_n, .data_out, .data_oe_n, .data_in,
		.ale, .rd_n, .wr_n);
	ext_mem_model mdl (.clk, .mux, .addr_hi_out, .addr_hi_oe_n, .addr_lo_out, .data_out, .ale,
		.rd_n, .wr_n, .data_in);
	initial forever #5 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic set(input logic [7:0] c, t, p);
		@(negedge clk);
		{cfg_wr, timing_wr, page_wr} = 3'h7;
		{cfg_wdata, timing_wdata, page_wdata} = {c, t, p};
		@(negedge clk);
		{cfg_wr, timing_wr, page_wr} = 3'h0;
	endtask
	// One move; counts cycles, latch and strobe cycles, and samples the pins
	task automatic move(input logic w, wr, input logic [15:0] dp, input logic [7:0] lp, wd);
		@(negedge clk);
		{req, req_wide, req_write, data_pointer, low_pointer, req_wdata} = {1'b1, w, wr, dp, lp, wd};
		@(negedge clk);
		req = 1'b0;
		n_ale = 0;
		n_stb = 0;
		hi_drv = 1'b0;
		for (n_cyc = 1; n_cyc < 100; n_cyc++) begin
			if (ale === 1'b1) begin
				n_ale++;
				ale_ad = data_oe_n ? ~data_out : data_out;
			end
			if (rd_n === 1'b0 || wr_n === 1'b0) begin
				n_stb++;
				hi_drv = ~addr_hi_oe_n;
				stb_hi = addr_hi_out;
				stb_lo = addr_lo_oe_n ? ~addr_lo_out : addr_lo_out;
				stb_d = data_oe_n ? ~data_out : data_out;
			end
			if (done === 1'b1) break;
			@(negedge clk);
		end
		if (n_cyc == 100) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic t_reset();
		check(interface_config_reg, xmem_pkg::CFG_RESET);
		check(interface_timing_reg, xmem_pkg::TC_RESET);
		check({addr_hi_oe_n, addr_lo_oe_n, data_oe_n, ale, rd_n, wr_n}, 6'h3B);
	endtask
	task automatic t_internal();
		set(8'h00, 8'h00, 8'h01);
		check(upper_page_reg, 8'h01);
		move(1'b1, 1'b1, 16'h1005, 8'h00, 8'hA5);
		check(n_cyc, 2);
		check({busy, done}, 2'h1);
		check(n_stb + n_ale, 0);
		move(1'b1, 1'b0, 16'h0005, 8'h00, 8'h00);
		check(rdata, 8'hA5);
		move(1'b0, 1'b1, 16'hFFFF, 8'h23, 8'h5A);
		move(1'b1, 1'b0, 16'h0123, 8'h00, 8'h00);
		check(rdata, 8'h5A);
	endtask
	task automatic t_timing();
		logic [7:0] tv [4] = '{8'h00, 8'h80, 8'h3C, 8'h03};
		int nv [4] = '{5, 7, 20, 8};
		int sv [4] = '{1, 1, 16, 1};
		for (int i = 0; i < 4; i++) begin
			set(8'h1C, tv[i], 8'h77);
			move(1'b1, 1'b1, 16'h0020, 8'h00, 8'h11);
			check(n_cyc, nv[i]);
			check(n_stb, sv[i]);
		end
	endtask
	task automatic t_ext();
		set(8'h1C, 8'h49, 8'h77);
		move(1'b1, 1'b1, 16'h0010, 8'h00, 8'h3C);
		check(n_cyc, 9);
		check(n_ale, 0);
		check({hi_drv, stb_hi, stb_lo}, {1'b1, 8'h00, 8'h10});
		check(mdl.mem[16'h0010], 8'h3C);
		move(1'b1, 1'b0, 16'h0010, 8'h00, 8'h00);
		check(rdata, 8'h3C);
		move(1'b0, 1'b1, 16'h0000, 8'h44, 8'h66);
		check(hi_drv, 1'b0);
		check(mdl.mem[16'hC344], 8'h66);
	endtask
	task automatic t_split();
		set(8'h14, 8'h00, 8'h20);
		move(1'b0, 1'b1, 16'h0000, 8'h01, 8'h71);
		check({hi_drv, stb_lo}, {1'b0, 8'h01});
		check(mdl.mem[16'hC301], 8'h71);
		move(1'b1, 1'b1, 16'h0100, 8'h00, 8'h72);
		check(n_cyc, 2);
		check(n_stb, 0);
		move(1'b1, 1'b1, 16'h2003, 8'h00, 8'h74);
		check({hi_drv, stb_hi}, {1'b1, 8'h20});
		set(8'h18, 8'h00, 8'h20);
		move(1'b0, 1'b1, 16'h0000, 8'h02, 8'h73);
		check({hi_drv, stb_hi, stb_lo}, {1'b1, 8'h20, 8'h02});
		check(mdl.mem[16'h2002], 8'h73);
	endtask
	task automatic t_mux();
		set(8'h0D, 8'h00, 8'h00);
		move(1'b1, 1'b1, 16'h1234, 8'h00, 8'h99);
		check(n_cyc, 9);
		check(n_ale, 2);
		check(ale_ad, 8'h34);
		check(stb_d, 8'h99);
		check(mdl.mem[16'h1234], 8'h99);
		move(1'b1, 1'b0, 16'h1234, 8'h00, 8'h00);
		check(rdata, 8'h99);
		set(8'h0C, 8'h00, 8'h00);
		move(1'b1, 1'b0, 16'h1234, 8'h00, 8'h00);
		check(n_cyc, 7);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_internal();
		t_timing();
		t_ext();
		t_split();
		t_mux();
		end_of_test();
	end
endmodule
`default_nettype wire
